/* power_state_supervisor.v */
// top-level power state supervisor: rail sequencing, controller reset, mirror park
// pins from the board are asynchronous; sw_* commands come from same-clock logic
`default_nettype none
`include "power_supervisor_map.vh"

module power_state_supervisor #(
  parameter CW = `WD_CNT_W,
  parameter TW = `TIMER_W,
  parameter RW = `RATIO_W,
  parameter [TW-1:0] RAIL_STEP_CYC = `RAIL_STEP_CYC,
  parameter [TW-1:0] RST_HOLD_CYC = `RST_HOLD_CYC,
  parameter [TW-1:0] PARK_HOLD_CYC = `PARK_HOLD_CYC,
  parameter [TW-1:0] DISCHARGE_CYC = `DISCHARGE_CYC,
  parameter [TW-1:0] RATIO_WIN_CYC = `RATIO_WIN_CYC
) (
  // clock, reset, enable
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire ce_i,
  // asynchronous pins
  input wire projector_on_request_i,
  input wire watchdog_input_a_i,
  input wire watchdog_input_b_i,
  input wire sequencer_clock_in_i,
  input wire main_supply_monitor_i,
  input wire rail_good_1v1_i,
  input wire rail_good_1v8_i,
  input wire rail_good_3v3_i,
  input wire analog_regulator_6v_input_i,
  input wire temp_warn_a_i,
  input wire temp_warn_b_i,
  input wire temp_err_a_i,
  input wire temp_err_b_i,
  // software commands
  input wire sw_power_cycle_i,
  input wire sw_park_i,
  input wire sw_mirror_start_i,
  input wire sw_mirror_done_i,
  input wire sw_illum_en_i,
  input wire hud_mode_i,
  // watchdog setup
  input wire wd_a_enable_i,
  input wire wd_b_enable_i,
  input wire [CW-1:0] wd_a_open_i,
  input wire [CW-1:0] wd_a_close_i,
  input wire [CW-1:0] wd_b_open_i,
  input wire [CW-1:0] wd_b_close_i,
  input wire wd_err_clear_i,
  // supply and controller outputs
  output wire en_1v1_o,
  output wire en_1v8_o,
  output wire en_3v3_o,
  output wire mirror_reg_en_o,
  output wire controller_reset_out_n_o,
  output wire mirror_park_out_n_o,
  // status
  output wire temp_warn_irq_o,
  output wire wd_a_err_o,
  output wire wd_b_err_o,
  output wire [`STATE_W-1:0] top_state_o,
  output wire [2:0] last_off_cause_o,
  output wire [RW-1:0] clock_ratio_o
);
  localparam [`STATE_W-1:0] S_OFF = 13'h0001;
  localparam [`STATE_W-1:0] S_RAIL1 = 13'h0002;
  localparam [`STATE_W-1:0] S_RAIL2 = 13'h0004;
  localparam [`STATE_W-1:0] S_RAIL3 = 13'h0008;
  localparam [`STATE_W-1:0] S_RAILWAIT = 13'h0010;
  localparam [`STATE_W-1:0] S_RSTHOLD = 13'h0020;
  localparam [`STATE_W-1:0] S_STANDBY = 13'h0040;
  localparam [`STATE_W-1:0] S_MIRROR = 13'h0080;
  localparam [`STATE_W-1:0] S_READY = 13'h0100;
  localparam [`STATE_W-1:0] S_IMAGE = 13'h0200;
  localparam [`STATE_W-1:0] S_PARK = 13'h0400;
  localparam [`STATE_W-1:0] S_DISCH = 13'h0800;
  localparam [`STATE_W-1:0] S_SHUTDOWN = 13'h1000;
  localparam NS = 13;

  // two-flop synchronisers, first stage read only by the second
  wire [NS-1:0] pins_a;
  reg [NS-1:0] sync1_q;
  reg [NS-1:0] sync2_q;
  assign pins_a = {projector_on_request_i, watchdog_input_a_i, watchdog_input_b_i, sequencer_clock_in_i,
                   main_supply_monitor_i, rail_good_1v1_i, rail_good_1v8_i, rail_good_3v3_i,
                   analog_regulator_6v_input_i, temp_warn_a_i, temp_warn_b_i, temp_err_a_i, temp_err_b_i};

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= {NS{1'b0}};
      sync2_q <= {NS{1'b0}};
    end else if (ce_i) begin
      sync1_q <= pins_a;
      sync2_q <= sync1_q;
    end
  end

  wire req = sync2_q[12];
  wire wd_a_s = sync2_q[11];
  wire wd_b_s = sync2_q[10];
  wire seqclk_s = sync2_q[9];
  wire main_good = sync2_q[8];
  wire rails_good = &sync2_q[7:4];
  wire temp_warn = sync2_q[3] | sync2_q[2];
  wire temp_err = sync2_q[1] | sync2_q[0];

  // edge history, fed only from the synchronised stage
  reg wd_a_d_q;
  reg wd_b_d_q;
  reg seqclk_d_q;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wd_a_d_q <= 1'b0;
      wd_b_d_q <= 1'b0;
      seqclk_d_q <= 1'b0;
    end else if (ce_i) begin
      wd_a_d_q <= wd_a_s;
      wd_b_d_q <= wd_b_s;
      seqclk_d_q <= seqclk_s;
    end
  end

  // both channels share one clear; each keeps its own window
  wire wd_a_pulse;
  wire wd_b_pulse;
  watchdog_channel #(.CW(CW)) u_wd_a (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .enable_i(wd_a_enable_i),
    .edge_i(wd_a_s & ~wd_a_d_q),
    .open_cyc_i(wd_a_open_i),
    .close_cyc_i(wd_a_close_i),
    .err_clear_i(wd_err_clear_i),
    .err_pulse_o(wd_a_pulse),
    .err_o(wd_a_err_o)
  );
  watchdog_channel #(.CW(CW)) u_wd_b (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .enable_i(wd_b_enable_i),
    .edge_i(wd_b_s & ~wd_b_d_q),
    .open_cyc_i(wd_b_open_i),
    .close_cyc_i(wd_b_close_i),
    .err_clear_i(wd_err_clear_i),
    .err_pulse_o(wd_b_pulse),
    .err_o(wd_b_err_o)
  );

  // clock ratio: sequencer edges counted over a fixed maintenance window
  reg [TW-1:0] win_q;
  reg [RW-1:0] edges_q;
  reg [RW-1:0] ratio_q;
  wire seq_rise = seqclk_s & ~seqclk_d_q;
  wire edges_full = (edges_q == {RW{1'b1}});
  wire [RW-1:0] edges_next = (seq_rise && !edges_full) ? edges_q + {{(RW-1){1'b0}}, 1'b1} : edges_q;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      win_q <= {TW{1'b0}};
      edges_q <= {RW{1'b0}};
      ratio_q <= {RW{1'b0}};
    end else if (ce_i) begin
      if (win_q >= RATIO_WIN_CYC - 1'b1) begin
        win_q <= {TW{1'b0}};
        ratio_q <= edges_next;
        edges_q <= {RW{1'b0}};
      end else begin
        win_q <= win_q + {{(TW-1){1'b0}}, 1'b1};
        // saturate rather than wrap so a fast clock never reads as slow
        edges_q <= edges_next;
      end
    end
  end
  assign clock_ratio_o = ratio_q;

  // state machine
  reg [`STATE_W-1:0] state_q;
  reg [`STATE_W-1:0] state_d;
  reg [TW-1:0] tmr_q;
  reg [2:0] cause_q;
  reg [2:0] cause_d;
  reg irq_q;
  wire wd_fault = (wd_a_enable_i & wd_a_pulse) | (wd_b_enable_i & wd_b_pulse);
  // a rail dropping counts as lost power here just as in standby
  wire power_bad = ~main_good | ~rails_good;
  wire park_evt = power_bad | ~req | temp_err | sw_park_i | sw_power_cycle_i;
  wire tmr_hold = temp_warn;

  // checks inside each state are listed in priority order
  always @* begin
    state_d = state_q;
    cause_d = cause_q;
    case (state_q)
      S_OFF: begin
        if (main_good && req && !temp_warn)
          state_d = S_RAIL1;
      end
      S_RAIL1, S_RAIL2, S_RAIL3, S_RAILWAIT, S_RSTHOLD: begin
        if (temp_err) begin
          state_d = S_SHUTDOWN;
        end else if (!main_good) begin
          state_d = S_OFF;
          cause_d = `CAUSE_POWER_ON;
        end else if (!tmr_hold) begin
          case (state_q)
            S_RAIL1: if (tmr_q >= RAIL_STEP_CYC) state_d = S_RAIL2;
            S_RAIL2: if (tmr_q >= RAIL_STEP_CYC) state_d = S_RAIL3;
            S_RAIL3: if (tmr_q >= RAIL_STEP_CYC) state_d = S_RAILWAIT;
            S_RAILWAIT: if (rails_good) state_d = S_RSTHOLD;
            S_RSTHOLD: if (tmr_q >= RST_HOLD_CYC) state_d = S_STANDBY;
            default: state_d = S_OFF;
          endcase
        end
      end
      S_STANDBY: begin
        if (temp_err) begin
          state_d = S_SHUTDOWN;
        end else if (!req) begin
          state_d = S_OFF;
          cause_d = `CAUSE_REQ_LOW;
        end else if (sw_power_cycle_i) begin
          state_d = S_OFF;
          cause_d = `CAUSE_SW_CYCLE;
        end else if (power_bad) begin
          state_d = S_OFF;
          cause_d = `CAUSE_POWER_ON;
        end else if (wd_fault) begin
          state_d = S_OFF;
          // channel a wins a tie; the other error stays in its sticky flag
          cause_d = (wd_a_enable_i & wd_a_pulse) ? `CAUSE_WD_A : `CAUSE_WD_B;
        end else if (sw_mirror_start_i) begin
          state_d = S_MIRROR;
        end
      end
      S_MIRROR: begin
        // request loss is deliberately ignored until powering completes
        if (sw_mirror_done_i)
          state_d = S_READY;
      end
      S_READY: begin
        if (park_evt)
          state_d = S_PARK;
        else if (hud_mode_i && sw_illum_en_i)
          state_d = S_IMAGE;
      end
      S_IMAGE: begin
        if (park_evt)
          state_d = S_PARK;
        else if (!sw_illum_en_i || !hud_mode_i)
          state_d = S_READY;
      end
      S_PARK: begin
        if (tmr_q >= PARK_HOLD_CYC)
          state_d = S_DISCH;
      end
      S_DISCH: begin
        if (tmr_q >= DISCHARGE_CYC)
          state_d = S_STANDBY;
      end
      S_SHUTDOWN: begin
        // a cleared error alone never leaves; the request or the main supply must drop first
        if (!req || !main_good) begin
          state_d = S_OFF;
          cause_d = `CAUSE_OVERTEMP;
        end
      end
      default: state_d = S_OFF;
    endcase
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= S_OFF;
      tmr_q <= {TW{1'b0}};
      cause_q <= `CAUSE_POWER_ON;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      cause_q <= cause_d;
      irq_q <= temp_warn;
      // timer saturates so a long stay can never wrap back below a limit
      if (state_d != state_q)
        tmr_q <= {TW{1'b0}};
      else if (!tmr_hold || state_q == S_PARK || state_q == S_DISCH)
        tmr_q <= (tmr_q == {TW{1'b1}}) ? tmr_q : tmr_q + {{(TW-1){1'b0}}, 1'b1};
    end
  end

  // outputs decoded from the registered state only, so reset forces them off at once
  wire rails_on = ~(state_q[0] | state_q[12]);
  assign en_1v1_o = rails_on;
  assign en_1v8_o = rails_on & ~state_q[1];
  assign en_3v3_o = rails_on & ~state_q[1] & ~state_q[2];
  assign mirror_reg_en_o = state_q[7] | state_q[8] | state_q[9] | state_q[10];
  assign controller_reset_out_n_o = state_q[6] | state_q[7] | state_q[8] | state_q[9] |
                                    state_q[10] | state_q[11];
  assign mirror_park_out_n_o = state_q[7] | state_q[8] | state_q[9];
  assign temp_warn_irq_o = irq_q;
  assign top_state_o = state_q;
  assign last_off_cause_o = cause_q;
endmodule // power_state_supervisor
`default_nettype wire

/* power_supervisor_map.vh */
// constants for the power state supervisor: timing, cause codes, widths
// assumes a 250 MHz system clock; included by bare name
//
// What this block does
// - each watchdog starts timing on its own input rising edge; channels independent
// - open and close window times come from programmable values; enable gates them
// - edge arriving before the window opens flags that channel's error
// - window closing without an edge flags that channel's error
// - every rising edge restarts timing; controller must pulse inside the window
// - either die temperature warning may raise an interrupt toward the controller
// - over-temperature error forces shutdown; request toggle restarts from low power
// - power-on steps pause while die temperature is at or above warning
// - ratio of maintenance oscillator to external sequencer clock is measured and readable
// - reset forces OFF, all supplies off, controller reset held low
// - leave OFF only with main supply good, request high, temperature below warning
// - rails enable one after another: lowest, middle, highest voltage
// - wait for all four monitored rails good before heading to STANDBY
// - hold controller reset low a fixed time after rails good, then release
// - over-temperature error in STANDBY goes to SHUTDOWN
// - STANDBY returns to OFF on request low, power cycle command, power loss
// - enabled watchdog error in STANDBY returns to OFF
// - software starting mirror supplies in STANDBY enters mirror powering state
// - software confirming mirror power moves to display ready
// - request low during mirror powering is acted on only after it completes
// - head-up mode toggles ready and image active; headlight mode stays ready
// - any park event from ready or image active goes to PARKING
// - PARKING drives park low, times out, drops mirror regulator, then STANDBY
// - SHUTDOWN only on over-temperature, all supplies off, exit on request low or power loss
// - record cause of last pass through OFF as a 3-bit code
`ifndef POWER_SUPERVISOR_MAP_VH
`define POWER_SUPERVISOR_MAP_VH

`define CLK_PERIOD_NS 4
`define RAIL_STEP_NS 100000
`define RST_HOLD_NS 10000000
`define PARK_HOLD_NS 1000000
`define DISCHARGE_NS 1000000
`define RATIO_WIN_NS 4000
`define RAIL_STEP_CYC ((`RAIL_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_HOLD_CYC ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PARK_HOLD_CYC ((`PARK_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DISCHARGE_CYC ((`DISCHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RATIO_WIN_CYC ((`RATIO_WIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CAUSE_POWER_ON 3'h0
`define CAUSE_REQ_LOW 3'h1
`define CAUSE_WD_A 3'h2
`define CAUSE_WD_B 3'h3
`define CAUSE_OVERTEMP 3'h4
`define CAUSE_SW_CYCLE 3'h5

`define WD_CNT_W 16
`define TIMER_W 24
`define RATIO_W 8
`define STATE_W 13

`endif

/* watchdog_channel.v */
// one windowed watchdog channel
// expects a one-cycle rising-edge pulse already synchronised to sys_clk_i
`default_nettype none
`include "power_supervisor_map.vh"

module watchdog_channel #(
  parameter CW = `WD_CNT_W
) (
  // clock and reset
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire ce_i,
  // control
  input wire enable_i,
  input wire edge_i,
  input wire [CW-1:0] open_cyc_i,
  input wire [CW-1:0] close_cyc_i,
  input wire err_clear_i,
  // status
  output wire err_pulse_o,
  output wire err_o
);
  reg armed_q;
  reg [CW-1:0] cnt_q;
  reg err_q;
  reg pulse;

  always @* begin
    pulse = 1'b0;
    if (enable_i && armed_q) begin
      if (edge_i)
        pulse = (cnt_q < open_cyc_i);
      else
        pulse = (cnt_q >= close_cyc_i);
    end
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed_q <= 1'b0;
      cnt_q <= {CW{1'b0}};
      err_q <= 1'b0;
    end else if (ce_i) begin
      if (!enable_i) begin
        armed_q <= 1'b0;
        cnt_q <= {CW{1'b0}};
      end else if (edge_i || pulse) begin
        armed_q <= 1'b1;
        cnt_q <= {CW{1'b0}};
      end else if (armed_q) begin
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
      // set wins over clear so an error is never lost
      if (pulse)
        err_q <= 1'b1;
      else if (err_clear_i)
        err_q <= 1'b0;
    end
  end

  assign err_pulse_o = pulse;
  assign err_o = err_q;
endmodule // watchdog_channel
`default_nettype wire

/* power_state_supervisor_asserts.sv */
// checker on the supervisor pins: off safety, rail order, reset hold, mirror, park
// assumes the design header on the include path; bound below
`default_nettype none
`include "power_supervisor_map.vh"
module power_state_supervisor_asserts #(
  parameter [23:0] RST_HOLD_CYC = 24'h1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // inputs
  input wire logic projector_on_request_i,
  input wire logic main_supply_monitor_i,
  input wire logic temp_warn_a_i,
  input wire logic temp_warn_b_i,
  input wire logic sw_mirror_start_i,
  input wire logic sw_mirror_done_i,
  // outputs
  input wire logic en_1v1_o,
  input wire logic en_1v8_o,
  input wire logic en_3v3_o,
  input wire logic mirror_reg_en_o,
  input wire logic controller_reset_out_n_o,
  input wire logic mirror_park_out_n_o,
  input wire logic [`STATE_W-1:0] top_state_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [23:0] hold_q;
  wire logic any_en = en_1v1_o | en_1v8_o | en_3v3_o | mirror_reg_en_o;
  // cycles spent in reset hold; longer when a warning pauses it
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i) hold_q <= 24'h0;
    else hold_q <= top_state_o[5] ? hold_q + 24'h1 : 24'h0;
  sequence s_leave_off;
    top_state_o[0] ##1 top_state_o[1];
  endsequence
  sequence s_enter_mirror;
    top_state_o[6] ##1 top_state_o[7];
  endsequence
  sequence s_leave_mirror;
    top_state_o[7] ##1 !top_state_o[7];
  endsequence
  AST_OFF_SAFE: assert property (top_state_o[0] |-> !any_en && !controller_reset_out_n_o)
    else $error("supply or controller active in off");
  AST_RAIL_ORDER: assert property ((en_1v8_o -> en_1v1_o) && (en_3v3_o -> en_1v8_o))
    else $error("rail enabled out of order");
  AST_RAIL_STEP: assert property ($rose(en_1v1_o) |-> !en_1v8_o [*8])
    else $error("second rail too early");
  // pins reach the state three edges late through the synchronisers
  AST_OFF_EXIT: assert property (s_leave_off |-> $past(projector_on_request_i, 3) &&
    $past(main_supply_monitor_i, 3) && !$past(temp_warn_a_i, 3) && !$past(temp_warn_b_i, 3))
    else $error("left off without its conditions");
  AST_RST_HOLD: assert property ($rose(controller_reset_out_n_o) |-> hold_q >= RST_HOLD_CYC)
    else $error("controller reset released early");
  AST_MIRROR_IN: assert property (s_enter_mirror |-> $past(sw_mirror_start_i))
    else $error("mirror powering without start");
  AST_MIRROR_OUT: assert property (s_leave_mirror |-> top_state_o[8] && $past(sw_mirror_done_i))
    else $error("mirror powering left wrongly");
  AST_PARK: assert property (top_state_o[10] |-> !mirror_park_out_n_o && mirror_reg_en_o)
    else $error("park outputs wrong");
  AST_DISCH: assert property (top_state_o[11] |-> !mirror_reg_en_o && !mirror_park_out_n_o)
    else $error("mirror regulator on in discharge");
  AST_SHUTDOWN: assert property (top_state_o[12] |-> !any_en)
    else $error("supply on in shutdown");
endmodule // power_state_supervisor_asserts
bind power_state_supervisor power_state_supervisor_asserts #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_chk (
  .sys_clk_i, .arst_n_i, .projector_on_request_i, .main_supply_monitor_i, .temp_warn_a_i,
  .temp_warn_b_i, .sw_mirror_start_i, .sw_mirror_done_i, .en_1v1_o, .en_1v8_o, .en_3v3_o,
  .mirror_reg_en_o, .controller_reset_out_n_o, .mirror_park_out_n_o, .top_state_o);
`default_nettype wire

/* controller_model.sv */
// controller side model: watchdog pulse trains and sequencer clock
// assumes the supervisor system clock; period 0 keeps a channel quiet
`default_nettype none
module controller_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // pulse periods in cycles
  input var int per_a_i,
  input var int per_b_i,
  // pins to the supervisor
  output var logic wd_a_o,
  output var logic wd_b_o,
  output var logic sequencer_clock_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int ca, cb;
  // free running, about 30 MHz
  initial begin
    sequencer_clock_in_o = 1'b0;
    forever #17 sequencer_clock_in_o = ~sequencer_clock_in_o;
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i) begin
      ca <= 0;
      cb <= 0;
    end else begin
      ca <= (per_a_i == 0 || ca >= per_a_i - 1) ? 0 : ca + 1;
      cb <= (per_b_i == 0 || cb >= per_b_i - 1) ? 0 : cb + 1;
    end
  // three cycles high so the synchroniser cannot miss a pulse
  assign wd_a_o = per_a_i != 0 && ca < 3;
  assign wd_b_o = per_b_i != 0 && cb < 3;
endmodule // controller_model
`default_nettype wire

/* system_power_state_supervisor_bench.sv */
// bench: boot walk, mirror and park, watchdogs, off causes, shutdown
// assumes the supervisor, its checker and controller_model compiled first
`default_nettype none
`include "power_supervisor_map.vh"
module system_power_state_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RS = 8;
  localparam int RH = 16;
  logic sys_clk_i, arst_n_i, req, main_ok, hud, ill, ce, ena, enb;
  logic [4:0] cmd;
  logic [3:0] rg;
  logic [1:0] tw, te;
  logic [15:0] bo, bc, ao, ac;
  wire logic wda, wdb, sck, e11, e18, e33, mre, crn, pkn, irq, aerr, berr;
  wire logic [`STATE_W-1:0] st;
  wire logic [2:0] cause;
  wire logic [7:0] ratio;
  int pa, pb, fail_count, checks, seed, n;
  power_state_supervisor #(.RAIL_STEP_CYC(24'h8), .RST_HOLD_CYC(24'h10), .PARK_HOLD_CYC(24'h8),
    .DISCHARGE_CYC(24'h8), .RATIO_WIN_CYC(24'h64)) DUT (
    .sys_clk_i, .arst_n_i, .ce_i(ce), .projector_on_request_i(req), .watchdog_input_a_i(wda),
    .watchdog_input_b_i(wdb), .sequencer_clock_in_i(sck), .main_supply_monitor_i(main_ok),
    .rail_good_1v1_i(rg[0]), .rail_good_1v8_i(rg[1]), .rail_good_3v3_i(rg[2]),
    .analog_regulator_6v_input_i(rg[3]), .temp_warn_a_i(tw[0]), .temp_warn_b_i(tw[1]),
    .temp_err_a_i(te[0]), .temp_err_b_i(te[1]), .sw_power_cycle_i(cmd[3]), .sw_park_i(cmd[2]),
    .sw_mirror_start_i(cmd[1]), .sw_mirror_done_i(cmd[0]), .sw_illum_en_i(ill), .hud_mode_i(hud),
    .wd_a_enable_i(ena), .wd_b_enable_i(enb), .wd_a_open_i(ao), .wd_a_close_i(ac),
    .wd_b_open_i(bo), .wd_b_close_i(bc), .wd_err_clear_i(cmd[4]), .en_1v1_o(e11), .en_1v8_o(e18),
    .en_3v3_o(e33), .mirror_reg_en_o(mre), .controller_reset_out_n_o(crn), .mirror_park_out_n_o(pkn),
    .temp_warn_irq_o(irq), .wd_a_err_o(aerr), .wd_b_err_o(berr), .top_state_o(st),
    .last_off_cause_o(cause), .clock_ratio_o(ratio));
  controller_model ctl (.sys_clk_i, .arst_n_i, .per_a_i(pa), .per_b_i(pb), .wd_a_o(wda),
    .wd_b_o(wdb), .sequencer_clock_in_o(sck));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (e !== s) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic pulse(input int b);
    @(posedge sys_clk_i);
    cmd <= 5'h1 << b;
    @(posedge sys_clk_i);
    cmd <= 5'h0;
    #1;
  endtask
  // bounded wait for a one-hot state; n returns the cycles waited
  task automatic to_st(input int b, input int lim);
    n = 0;
    while (st[b] !== 1'b1 && n < lim) begin
      tk(1);
      n++;
    end
    chk("state", 16'(1 << b), 16'(st));
  endtask
  task automatic boot;
    int q[$] = '{1, 2, 3, 4};
    @(posedge sys_clk_i);
    {req, main_ok, tw, rg} <= 8'hc0;
    foreach (q[i]) begin
      to_st(q[i], 40);
      chk("rails", 16'((1 << (i < 2 ? i + 1 : 3)) - 1), 16'({e33, e18, e11}));
      if (i > 0) chk("rail dwell", 16'(RS + 1), 16'(n));
    end
    @(posedge sys_clk_i);
    rg <= 4'h7;
    tk(20);
    chk("rail wait", 16'h10, 16'(st));
    @(posedge sys_clk_i);
    rg <= 4'hf;
    to_st(5, 10);
    chk("ctl reset", 16'h0, 16'(crn));
    to_st(6, RH + 10);
    chk("reset hold", 16'(RH + 1), 16'(n));
    chk("ctl reset", 16'h1, 16'(crn));
  endtask
  // main supply dropped after so the state rests in off
  task automatic off_by(input logic [2:0] c);
    to_st(0, 200);
    tk(1);
    chk("off cause", 16'(c), 16'(cause));
    @(posedge sys_clk_i);
    {main_ok, rg} <= 5'h0;
    tk(8);
    to_st(0, 10);
  endtask
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  initial begin
    seed = 57;
    {arst_n_i, cmd, hud, ill, te, rg} = '0;
    {req, main_ok, tw, ce, ena, enb} = 7'h7f;
    ao = 16'h1e;
    ac = 16'h3c;
    bo = 16'h14 + 16'($random(seed) & 15);
    bc = bo + 16'h28;
    pa = 45;
    pb = int'(bo) + 15;
    repeat (5) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    tk(20);
    chk("state", 16'h1, 16'(st));
    chk("reset outs", 16'h0, 16'({crn, pkn, cause}));
    chk("warn irq", 16'h1, 16'(irq));
    boot();
    tk(200);
    chk("wd quiet", 16'h40, 16'({aerr, berr, st}));
    chk("warn irq", 16'h0, 16'(irq));
    chk("ratio", 16'h1, 16'(ratio >= 8'd11 && ratio <= 8'd12));
    pulse(1);
    chk("state", 16'h80, 16'(st));
    pulse(0);
    chk("state", 16'h100, 16'(st));
    @(posedge sys_clk_i);
    {hud, ill} <= 2'b11;
    tk(2);
    chk("state", 16'h200, 16'(st));
    @(posedge sys_clk_i);
    {hud, ill} <= 2'b10;
    tk(2);
    chk("state", 16'h100, 16'(st));
    @(posedge sys_clk_i);
    {hud, ill} <= 2'b01;
    tk(10);
    chk("state", 16'h100, 16'(st));
    // two frozen edges: a park command must not be taken
    @(posedge sys_clk_i);
    ce <= 1'b0;
    cmd <= 5'h4;
    tk(1);
    chk("frozen", 16'h100, 16'(st));
    @(posedge sys_clk_i);
    ce <= 1'b1;
    cmd <= 5'h0;
    pulse(2);
    chk("park", 16'h1001, 16'({st, pkn, mre}));
    to_st(11, 20);
    to_st(6, 20);
    pulse(1);
    @(posedge sys_clk_i);
    req <= 1'b0;
    tk(20);
    chk("state", 16'h80, 16'(st));
    pulse(0);
    to_st(10, 10);
    to_st(6, 40);
    off_by(3'h1);
    boot();
    @(posedge sys_clk_i);
    pa <= 10;
    off_by(3'h2);
    chk("wd errs", 16'h2, 16'({aerr, berr}));
    @(posedge sys_clk_i);
    pa <= 45;
    tk(10);
    pulse(4);
    boot();
    @(posedge sys_clk_i);
    pa <= 0;
    off_by(3'h2);
    @(posedge sys_clk_i);
    pa <= 45;
    tk(60);
    pulse(4);
    boot();
    @(posedge sys_clk_i);
    {ena, enb} <= 2'b00;
    ao <= 16'h32;
    tk(100);
    chk("wd disabled", 16'h40, 16'(st));
    @(posedge sys_clk_i);
    {ena, enb} <= 2'b11;
    off_by(3'h2);
    @(posedge sys_clk_i);
    ao <= 16'h1e;
    tk(10);
    pulse(4);
    boot();
    @(posedge sys_clk_i);
    bc <= bo + 16'h8;
    off_by(3'h3);
    chk("wd errs", 16'h1, 16'({aerr, berr}));
    @(posedge sys_clk_i);
    bc <= bo + 16'h28;
    tk(60);
    pulse(4);
    boot();
    pulse(3);
    off_by(3'h5);
    boot();
    @(posedge sys_clk_i);
    main_ok <= 1'b0;
    off_by(3'h0);
    boot();
    @(posedge sys_clk_i);
    te <= 2'b11;
    to_st(12, 10);
    chk("shutdown en", 16'h0, 16'({e33, e18, e11, mre}));
    @(posedge sys_clk_i);
    {te, req} <= 3'b000;
    to_st(0, 10);
    boot();
    // reset in mid-run must drop everything at once, not at the next edge
    @(posedge sys_clk_i);
    arst_n_i <= 1'b0;
    #1;
    chk("async off", 16'h1, 16'({e11, crn, st}));
    @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    to_st(1, 10);
    chk("off cause", 16'h0, 16'(cause));
    end_of_test();
  end
endmodule // system_power_state_supervisor_bench
`default_nettype wire
